// ### src/rcg_defs.svh
// Offsets, field positions, reset values and timing figures of the receiver control/GPIO block.
// Assumes inclusion by bare name from the package and from every design module.
// Functional notes
// - Two-wire port works at 100 kHz, 400 kHz and 1 MHz; master stays below.
// - Default is a local slave port; select pin picks serial or two-wire.
// - Local port reaches every receiver register, none on the transmitter side.
// - Loaded configuration bit 6 turns slave pins into GPIO pins.
// - Status register: bit 7 configuration result, bit 6 chosen interface option.
// - GPIO option maps select, data-out, clock to outputs 2,1,0, inputs 3,2, irq.
// - GPIO registers are reachable only in slave option, where they are detached from pins; GPIO option has no port.
// - In slave option the interrupt pin shows only the wake flag.
// - Plain outputs drive the low four bits of the GPIO output register.
// - Bits 7..4 of the GPIO output register enable strong drive per output.
// - PWM field 7:6 code 11 routes PWM to output 3; 00 leaves it off.
// - PWM rate is 16 MHz divided by 255 times one plus field 5:0.
// - Eight-bit duty register sets PWM high time and resets to zero.
// - Mirror mode makes outputs 2..0 follow transmitter digital inputs.
// - Input-level register shows general inputs 3..0 in GPIO option, 1..0 in slave option; bits 7..4 read zero.
`ifndef RCG_DEFS_SVH
`define RCG_DEFS_SVH

`define RCG_ADDR_CFG_STATUS 7'h06
`define RCG_ADDR_INPUT_LEVELS 7'h07
`define RCG_ADDR_GPIO_OUT 7'h41
`define RCG_ADDR_PWM_CTRL 7'h42
`define RCG_ADDR_PWM_DUTY 7'h43

`define RCG_RST_CFG_STATUS 8'h00
`define RCG_RST_GPIO_OUT 8'h00
`define RCG_RST_PWM_CTRL 8'h00
`define RCG_RST_PWM_DUTY 8'h00

`define RCG_STAT_EXEC_BIT 7
`define RCG_STAT_GPIO_BIT 6
`define RCG_PWM_MODE_ON 2'h3
`define RCG_SPI_RW_BIT 7
`define RCG_TW_ADDR_LOW 6'h29

`define RCG_PWM_PERIOD_TICKS 255
`define RCG_REF_KHZ 16000
`define RCG_CLK_KHZ 25000

`endif

// ### src/rcg_pkg.sv
// Types shared by the receiver control/GPIO design files.
// Assumes rcg_defs.svh on the include path.
`include "rcg_defs.svh"
package rcg_pkg;

   typedef enum logic [7:0] {
      TW_IDLE  = 8'h01,
      TW_ADDR  = 8'h02,
      TW_ACK_A = 8'h04,
      TW_REG   = 8'h08,
      TW_ACK_R = 8'h10,
      TW_WDATA = 8'h20,
      TW_RDATA = 8'h40,
      TW_RACK  = 8'h80
   } rcg_tw_state_t;

   typedef struct packed {
      logic active;
      logic have_cmd;
      logic is_read;
      logic [2:0] cnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic miso;
      logic [6:0] addr;
   } rcg_spi_st_t;

   typedef struct packed {
      rcg_tw_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic sda_low;
      logic is_read;
      logic acked;
      logic [6:0] addr;
   } rcg_tw_st_t;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } rcg_wr_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] gpio_out;
      logic [7:0] pwm_ctrl;
      logic [7:0] pwm_duty;
      logic addr_strap;
      logic [1:0] boot_cnt;
   } rcg_regs_t;

   typedef struct packed {
      logic p1_o;
      logic p1_oe;
      logic p2_o;
      logic p2_oe;
      logic p3_o;
      logic p3_oe;
      logic irq;
      logic [3:0] boost;
   } rcg_pins_t;

endpackage

// ### src/rcg_pwm_gen.sv
// PWM generator for general output 3, stepping on a 16 MHz reference derived from clock_i.
// Assumes enable, rate and duty come from registers in the same clock domain.
`include "rcg_defs.svh"
module rcg_pwm_gen #(
   parameter int REF_KHZ = `RCG_REF_KHZ,
   parameter int CLK_KHZ = `RCG_CLK_KHZ,
   parameter int PERIOD = `RCG_PWM_PERIOD_TICKS
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic enable_i,
   input wire logic [5:0] rate_i,
   input wire logic [7:0] duty_i,
   output logic pwm_o
);

   localparam logic [15:0] REF_STEP = 16'(REF_KHZ);
   localparam logic [15:0] CLK_WRAP = 16'(CLK_KHZ);
   localparam logic [7:0] LAST_TICK = 8'(PERIOD - 1);

   logic [15:0] acc_reg, acc_next;
   logic [5:0] pre_reg, pre_next;
   logic [7:0] per_reg, per_next;
   logic out_reg, out_next;
   logic ref_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Fractional accumulator gives 16 MHz ticks on average; jitter is one clock_i
   always_comb begin
      acc_next = acc_reg + REF_STEP;
      ref_tick = 1'b0;
      pre_next = pre_reg;
      per_next = per_reg;
      out_next = 1'b0;
      if (acc_next >= CLK_WRAP) begin
         acc_next = acc_next - CLK_WRAP;
         ref_tick = 1'b1;
      end
      if (ref_tick) begin
         if (pre_reg == rate_i) begin
            pre_next = 6'h00;
            per_next = (per_reg == LAST_TICK) ? 8'h00 : per_reg + 8'h01;
         end else begin
            pre_next = pre_reg + 6'h01;
         end
      end
      if (enable_i) begin
         out_next = (per_reg < duty_i);
      end else begin
         acc_next = 16'h0000;
         pre_next = 6'h00;
         per_next = 8'h00;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_reg <= 16'h0000;
         pre_reg <= 6'h00;
         per_reg <= 8'h00;
         out_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         pre_reg <= pre_next;
         per_reg <= per_next;
         out_reg <= out_next;
      end
   end

   assign pwm_o = out_reg;

endmodule

// ### src/rcg_receiver_control_gpio_pwm.sv
// Receiver-side control port option: serial or two-wire slave, or GPIO pins with PWM.
// Assumes pins and general_inputs_lo_i are asynchronous; all other inputs are on clock_i.
`include "rcg_defs.svh"
module rcg_receiver_control_gpio_pwm (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic p1_sel_out2_i,
   output logic p1_sel_out2_o,
   output logic p1_sel_out2_oe_o,
   input wire logic p2_data_out1_i,
   output logic p2_data_out1_o,
   output logic p2_data_out1_oe_o,
   input wire logic p3_clock_out0_i,
   output logic p3_clock_out0_o,
   output logic p3_clock_out0_oe_o,
   input wire logic p4_csn_in3_i,
   input wire logic p6_din_in2_i,
   output logic p36_irq_out3_o,
   input wire logic [1:0] general_inputs_lo_i,
   output logic [3:0] drive_boost_o,
   input wire logic config_load_done_i,
   input wire logic config_exec_ok_i,
   input wire logic config_gpio_sel_i,
   input wire logic mirror_enable_i,
   input wire logic [2:0] transmitter_digital_inputs_i,
   input wire logic wake_flag_i,
   output logic [6:0] ext_addr_o,
   input wire logic [7:0] ext_rdata_i,
   output logic ext_we_o,
   output logic [6:0] ext_waddr_o,
   output logic [7:0] ext_wdata_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; bit order sel, data, clock, csn, din, lo[1:0]
   logic [6:0] sync1_reg, sync2_reg, prev_reg;
   logic pin_sel, pin_sda, pin_clk, pin_csn, pin_din;
   logic clk_rise, clk_fall, sda_rise, sda_fall;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= 7'h7f;
         sync2_reg <= 7'h7f;
         prev_reg <= 7'h7f;
      end else begin
         sync1_reg <= {p1_sel_out2_i, p2_data_out1_i, p3_clock_out0_i, p4_csn_in3_i,
                       p6_din_in2_i, general_inputs_lo_i};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   assign pin_sel = sync2_reg[6];
   assign pin_sda = sync2_reg[5];
   assign pin_clk = sync2_reg[4];
   assign pin_csn = sync2_reg[3];
   assign pin_din = sync2_reg[2];
   // Clock edges found by sampling; a 25 MHz clock keeps up to about 8 MHz links only
   assign clk_rise = pin_clk & ~prev_reg[4];
   assign clk_fall = ~pin_clk & prev_reg[4];
   assign sda_rise = pin_sda & ~prev_reg[5];
   assign sda_fall = ~pin_sda & prev_reg[5];

   ////////////////////////////////////////////////////////////////////////////////
   // Option decode
   rcg_pkg::rcg_regs_t regs_reg, regs_next;
   rcg_pkg::rcg_spi_st_t spi_reg, spi_next;
   rcg_pkg::rcg_tw_st_t tw_reg, tw_next;
   rcg_pkg::rcg_wr_t spi_wr, tw_wr, wr, ext_reg, ext_next;
   logic gpio_mode, spi_en, tw_en, pwm_on, pwm_out;
   logic [3:0] in_levels, dout;
   logic [6:0] rd_addr;

   assign gpio_mode = regs_reg.status[`RCG_STAT_GPIO_BIT];
   assign spi_en = ~gpio_mode & ~pin_sel;
   assign tw_en = ~gpio_mode & pin_sel;
   assign pwm_on = (regs_reg.pwm_ctrl[7:6] == `RCG_PWM_MODE_ON);
   // In slave option the upper inputs are detached from their pins
   assign in_levels = gpio_mode ? {pin_csn, pin_din, sync2_reg[1:0]}
                                : {2'h0, sync2_reg[1:0]};

   // Registers not held here are answered by the rest of the receiver
   function automatic logic [7:0] reg_read(input logic [6:0] a);
      case (a)
         `RCG_ADDR_CFG_STATUS: reg_read = regs_reg.status;
         `RCG_ADDR_INPUT_LEVELS: reg_read = {4'h0, in_levels};
         `RCG_ADDR_GPIO_OUT: reg_read = regs_reg.gpio_out;
         `RCG_ADDR_PWM_CTRL: reg_read = regs_reg.pwm_ctrl;
         `RCG_ADDR_PWM_DUTY: reg_read = regs_reg.pwm_duty;
         default: reg_read = ext_rdata_i;
      endcase
   endfunction

   function automatic logic is_local(input logic [6:0] a);
      is_local = (a == `RCG_ADDR_CFG_STATUS) || (a == `RCG_ADDR_INPUT_LEVELS) ||
                 (a == `RCG_ADDR_GPIO_OUT) || (a == `RCG_ADDR_PWM_CTRL) ||
                 (a == `RCG_ADDR_PWM_DUTY);
   endfunction

   assign rd_addr = tw_en ? tw_reg.addr :
                    (spi_reg.have_cmd ? spi_reg.addr : {spi_reg.rx[5:0], pin_din});
   assign ext_addr_o = rd_addr;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial slave: command byte then data bytes with address auto-increment
   always_comb begin
      logic [7:0] rx_full;
      rx_full = {spi_reg.rx[6:0], pin_din};
      spi_next = spi_reg;
      spi_wr = '0;
      if (!spi_en || pin_csn) begin
         spi_next.active = 1'b0;
         spi_next.have_cmd = 1'b0;
         spi_next.is_read = 1'b0;
         spi_next.cnt = 3'h0;
         spi_next.tx = 8'h00;
         spi_next.miso = 1'b0;
      end else begin
         spi_next.active = 1'b1;
         if (clk_rise) begin
            spi_next.rx = rx_full;
            spi_next.cnt = spi_reg.cnt + 3'h1;
            if (spi_reg.cnt == 3'h7) begin
               if (!spi_reg.have_cmd) begin
                  spi_next.have_cmd = 1'b1;
                  spi_next.is_read = rx_full[`RCG_SPI_RW_BIT];
                  spi_next.addr = rx_full[6:0];
                  if (rx_full[`RCG_SPI_RW_BIT]) begin
                     spi_next.tx = reg_read(rd_addr);
                     spi_next.addr = rx_full[6:0] + 7'h01;
                  end
               end else if (spi_reg.is_read) begin
                  spi_next.tx = reg_read(rd_addr);
                  spi_next.addr = spi_reg.addr + 7'h01;
               end else begin
                  spi_wr = '{we: 1'b1, addr: spi_reg.addr, data: rx_full};
                  spi_next.addr = spi_reg.addr + 7'h01;
               end
            end
         end
         if (clk_fall) begin
            spi_next.miso = spi_reg.tx[7];
            spi_next.tx = {spi_reg.tx[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         spi_reg <= '0;
      end else begin
         spi_reg <= spi_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-wire slave; no clock stretching, so every rate up to 1 MHz needs no wait
   always_comb begin
      tw_next = tw_reg;
      tw_wr = '0;
      if (!tw_en) begin
         tw_next.st = rcg_pkg::TW_IDLE;
         tw_next.sda_low = 1'b0;
         tw_next.cnt = 4'h0;
      end else if (pin_clk && sda_fall) begin
         tw_next.st = rcg_pkg::TW_ADDR;
         tw_next.cnt = 4'h0;
         tw_next.sda_low = 1'b0;
      end else if (pin_clk && sda_rise) begin
         tw_next.st = rcg_pkg::TW_IDLE;
         tw_next.sda_low = 1'b0;
      end else begin
         unique case (tw_reg.st)
            rcg_pkg::TW_IDLE: begin
            end
            rcg_pkg::TW_ADDR, rcg_pkg::TW_REG, rcg_pkg::TW_WDATA: begin
               if (clk_rise) begin
                  tw_next.sh = {tw_reg.sh[6:0], pin_sda};
                  tw_next.cnt = tw_reg.cnt + 4'h1;
               end
               if (clk_fall && tw_reg.cnt == 4'h8) begin
                  tw_next.cnt = 4'h0;
                  tw_next.sda_low = 1'b1;
                  if (tw_reg.st == rcg_pkg::TW_ADDR) begin
                     tw_next.is_read = tw_reg.sh[0];
                     tw_next.st = rcg_pkg::TW_ACK_A;
                     if (tw_reg.sh[7:1] != {regs_reg.addr_strap, `RCG_TW_ADDR_LOW}) begin
                        tw_next.st = rcg_pkg::TW_IDLE;
                        tw_next.sda_low = 1'b0;
                     end
                  end else if (tw_reg.st == rcg_pkg::TW_REG) begin
                     tw_next.addr = tw_reg.sh[6:0];
                     tw_next.st = rcg_pkg::TW_ACK_R;
                  end else begin
                     tw_wr = '{we: 1'b1, addr: tw_reg.addr, data: tw_reg.sh};
                     tw_next.addr = tw_reg.addr + 7'h01;
                     tw_next.st = rcg_pkg::TW_ACK_R;
                  end
               end
            end
            rcg_pkg::TW_ACK_A, rcg_pkg::TW_ACK_R, rcg_pkg::TW_RACK: begin
               if (clk_rise && tw_reg.st == rcg_pkg::TW_RACK) begin
                  tw_next.acked = ~pin_sda;
               end
               if (clk_fall) begin
                  tw_next.sda_low = 1'b0;
                  tw_next.cnt = 4'h0;
                  if (tw_reg.st == rcg_pkg::TW_ACK_R) begin
                     tw_next.st = rcg_pkg::TW_WDATA;
                  end else if (tw_reg.st == rcg_pkg::TW_ACK_A && !tw_reg.is_read) begin
                     tw_next.st = rcg_pkg::TW_REG;
                  end else if (tw_reg.st == rcg_pkg::TW_RACK && !tw_reg.acked) begin
                     tw_next.st = rcg_pkg::TW_IDLE;
                  end else begin
                     tw_next.sh = reg_read(rd_addr);
                     tw_next.sda_low = ~tw_next.sh[7];
                     tw_next.addr = tw_reg.addr + 7'h01;
                     tw_next.st = rcg_pkg::TW_RDATA;
                  end
               end
            end
            rcg_pkg::TW_RDATA: begin
               if (clk_rise) begin
                  tw_next.cnt = tw_reg.cnt + 4'h1;
               end
               if (clk_fall) begin
                  if (tw_reg.cnt == 4'h8) begin
                     tw_next.sda_low = 1'b0;
                     tw_next.acked = 1'b0;
                     tw_next.st = rcg_pkg::TW_RACK;
                  end else begin
                     tw_next.sh = {tw_reg.sh[6:0], 1'b0};
                     tw_next.sda_low = ~tw_reg.sh[6];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tw_reg <= '{st: rcg_pkg::TW_IDLE, default: '0};
      end else begin
         tw_reg <= tw_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file; status is read-only and only the configuration loader sets it
   assign wr = spi_wr | tw_wr;

   always_comb begin
      regs_next = regs_reg;
      ext_next = '{we: 1'b0, addr: ext_reg.addr, data: ext_reg.data};
      if (regs_reg.boot_cnt != 2'h3) begin
         // Address strap is loaded on the first three edges; the third load sees the filled synchroniser
         regs_next.boot_cnt = regs_reg.boot_cnt + 2'h1;
         regs_next.addr_strap = pin_csn;
      end
      if (config_load_done_i) begin
         regs_next.status = {config_exec_ok_i, config_gpio_sel_i, 6'h00};
      end
      if (wr.we) begin
         case (wr.addr)
            `RCG_ADDR_GPIO_OUT: regs_next.gpio_out = wr.data;
            `RCG_ADDR_PWM_CTRL: regs_next.pwm_ctrl = wr.data;
            `RCG_ADDR_PWM_DUTY: regs_next.pwm_duty = wr.data;
            default: begin
            end
         endcase
         if (!is_local(wr.addr)) begin
            ext_next = wr;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         regs_reg <= '{status: `RCG_RST_CFG_STATUS, gpio_out: `RCG_RST_GPIO_OUT,
                       pwm_ctrl: `RCG_RST_PWM_CTRL, pwm_duty: `RCG_RST_PWM_DUTY,
                       addr_strap: 1'b0, boot_cnt: 2'h0};
         ext_reg <= '0;
      end else begin
         regs_reg <= regs_next;
         ext_reg <= ext_next;
      end
   end

   assign ext_we_o = ext_reg.we;
   assign ext_waddr_o = ext_reg.addr;
   assign ext_wdata_o = ext_reg.data;

   ////////////////////////////////////////////////////////////////////////////////
   // PWM and pin drive
   rcg_pwm_gen u_pwm (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .enable_i(pwm_on),
      .rate_i(regs_reg.pwm_ctrl[5:0]),
      .duty_i(regs_reg.pwm_duty),
      .pwm_o(pwm_out)
   );

   assign dout[2:0] = mirror_enable_i ? transmitter_digital_inputs_i
                                      : regs_reg.gpio_out[2:0];
   assign dout[3] = pwm_on ? pwm_out : regs_reg.gpio_out[3];

   rcg_pkg::rcg_pins_t pins_reg, pins_next;

   always_comb begin
      if (gpio_mode) begin
         pins_next = '{p1_o: dout[2], p1_oe: 1'b1, p2_o: dout[1], p2_oe: 1'b1,
                       p3_o: dout[0], p3_oe: 1'b1, irq: dout[3],
                       boost: regs_reg.gpio_out[7:4]};
      end else begin
         // Slave option: GPIO registers keep their values but reach no pin
         pins_next = '{p1_o: 1'b0, p1_oe: 1'b0, p2_o: spi_en & spi_reg.miso,
                       p2_oe: (spi_en & spi_reg.active) | (tw_en & tw_reg.sda_low),
                       p3_o: 1'b0, p3_oe: 1'b0, irq: wake_flag_i,
                       boost: 4'h0};
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pins_reg <= '0;
      end else begin
         pins_reg <= pins_next;
      end
   end

   assign p1_sel_out2_o = pins_reg.p1_o;
   assign p1_sel_out2_oe_o = pins_reg.p1_oe;
   assign p2_data_out1_o = pins_reg.p2_o;
   assign p2_data_out1_oe_o = pins_reg.p2_oe;
   assign p3_clock_out0_o = pins_reg.p3_o;
   assign p3_clock_out0_oe_o = pins_reg.p3_oe;
   assign p36_irq_out3_o = pins_reg.irq;
   assign drive_boost_o = pins_reg.boost;

endmodule

// ### bench/rcg_spi_master.sv
// External controller model: serial master on the receiver's local slave port.
// Assumes the bench calls xfer only between frame(1) and frame(0); pins change at falling clock_i.
module rcg_spi_master (
   input wire logic clock_i,
   input wire logic miso_i,
   output logic sck_o,
   output logic csn_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // 160 ns half period gives 3.1 MHz, well inside the sampled-edge budget
   localparam int HALF = 4;
   initial begin
      sck_o = 1'b0;
      csn_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic frame(input logic on);
      repeat (HALF) @(negedge clock_i);
      csn_n_o = !on;
      // A released data line keeps moving so a stale bit is never mistaken for data
      mosi_o = !mosi_o;
      repeat (HALF) @(negedge clock_i);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_o = tx[i];
         repeat (HALF) @(negedge clock_i);
         rx[i] = miso_i;
         sck_o = 1'b1;
         repeat (HALF) @(negedge clock_i);
         sck_o = 1'b0;
      end
      repeat (HALF) @(negedge clock_i);
   endtask
endmodule

// ### bench/rcg_checker.sv
// Port-level checks of the receiver control/GPIO block.
// Assumes rcg_defs.svh on the include path; attached by the bind at the foot.
`include "rcg_defs.svh"
module rcg_checker (
   input wire logic clock_i, rstn_i, p1_sel_out2_i, p4_csn_in3_i, wake_flag_i,
   input wire logic config_load_done_i, config_gpio_sel_i, mirror_enable_i,
   input wire logic [2:0] transmitter_digital_inputs_i,
   input wire logic p1_sel_out2_o, p1_sel_out2_oe_o, p2_data_out1_o, p2_data_out1_oe_o,
   input wire logic p3_clock_out0_o, p3_clock_out0_oe_o, p36_irq_out3_o, ext_we_o,
   input wire logic [3:0] drive_boost_o,
   input wire logic [6:0] ext_waddr_o
);
   logic gpio_reg, slv_reg, gpo_reg;
   logic gpio_next, slv_next, gpo_next;
   wire slave_st = !gpio_reg && slv_reg;
   wire gpio_st = gpio_reg && gpo_reg;
   // Mode must hold two edges before pins reflect it, since pin outputs are registered
   always_comb begin
      gpio_next = config_load_done_i ? config_gpio_sel_i : gpio_reg;
      slv_next = !gpio_reg;
      gpo_next = gpio_reg;
   end
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gpio_reg <= 1'b0;
         slv_reg <= 1'b0;
         gpo_reg <= 1'b0;
      end else begin
         gpio_reg <= gpio_next;
         slv_reg <= slv_next;
         gpo_reg <= gpo_next;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);
   property p_reset_default;
      $rose(rstn_i) |-> !p1_sel_out2_oe_o && !p3_clock_out0_oe_o && drive_boost_o == 4'h0;
   endproperty
   property p_slave_detached;
      slave_st |-> drive_boost_o == 4'h0 && !p1_sel_out2_oe_o && !p3_clock_out0_oe_o;
   endproperty
   property p_gpio_drives;
      gpio_st |-> p1_sel_out2_oe_o && p2_data_out1_oe_o && p3_clock_out0_oe_o;
   endproperty
   property p_wake_irq;
      slave_st |-> p36_irq_out3_o == $past(wake_flag_i);
   endproperty
   property p_mirror;
      gpio_st && $past(mirror_enable_i) |->
         {p1_sel_out2_o, p2_data_out1_o, p3_clock_out0_o} == $past(transmitter_digital_inputs_i);
   endproperty
   property p_local_not_forwarded;
      ext_we_o |-> !(ext_waddr_o inside {`RCG_ADDR_CFG_STATUS, `RCG_ADDR_INPUT_LEVELS,
         `RCG_ADDR_GPIO_OUT, `RCG_ADDR_PWM_CTRL, `RCG_ADDR_PWM_DUTY});
   endproperty
   property p_serial_out_released;
      (slave_st && !p1_sel_out2_i && p4_csn_in3_i) [*5] |-> !p2_data_out1_oe_o;
   endproperty
   property p_gpio_no_port;
      gpio_st && $past(gpio_st) |-> $stable(drive_boost_o) && !ext_we_o;
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("pins on after reset");
   a_slave_detached: assert property (p_slave_detached) else $error("gpio drive slave");
   a_gpio_drives: assert property (p_gpio_drives) else $error("gpio outputs not driven");
   a_wake_irq: assert property (p_wake_irq) else $error("irq not wake flag");
   a_mirror: assert property (p_mirror) else $error("mirror outputs wrong");
   a_local_not_forwarded: assert property (p_local_not_forwarded) else $error("leaked");
   a_serial_out_released: assert property (p_serial_out_released) else $error("out held");
   a_gpio_no_port: assert property (p_gpio_no_port) else $error("port alive in gpio");
   c_gpio_high: cover property (gpio_st && p36_irq_out3_o);
   c_forward: cover property (ext_we_o);
   c_mirror: cover property (gpio_st && mirror_enable_i);
endmodule

bind rcg_receiver_control_gpio_pwm rcg_checker chk (.clock_i(clock_i), .rstn_i(rstn_i),
   .p1_sel_out2_i(p1_sel_out2_i), .p4_csn_in3_i(p4_csn_in3_i), .wake_flag_i(wake_flag_i),
   .config_load_done_i(config_load_done_i), .config_gpio_sel_i(config_gpio_sel_i),
   .mirror_enable_i(mirror_enable_i), .transmitter_digital_inputs_i(transmitter_digital_inputs_i),
   .p1_sel_out2_o(p1_sel_out2_o), .p1_sel_out2_oe_o(p1_sel_out2_oe_o),
   .p2_data_out1_o(p2_data_out1_o), .p2_data_out1_oe_o(p2_data_out1_oe_o),
   .p3_clock_out0_o(p3_clock_out0_o), .p3_clock_out0_oe_o(p3_clock_out0_oe_o),
   .p36_irq_out3_o(p36_irq_out3_o), .ext_we_o(ext_we_o), .drive_boost_o(drive_boost_o),
   .ext_waddr_o(ext_waddr_o));

// ### bench/rcg_receiver_control_gpio_pwm_tb.sv
// Self-checking bench: registers over the serial slave port, then GPIO option pins and PWM.
// Assumes design sources, rcg_spi_master and rcg_checker are compiled first.
`include "rcg_defs.svh"
module rcg_receiver_control_gpio_pwm_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0, rstn_i = 1'b0;
   logic sel, load, ok, gsel, mir, wake;
   logic [1:0] gin;
   logic [2:0] tdi;
   logic sck, csn_n, mosi, p1o, p1oe, p2o, p2oe, p3o, p3oe, pwm, we;
   logic [3:0] boost;
   logic [6:0] ea, wa;
   logic [7:0] wd, x;
   int miscompares = 0, n_compared = 0, cycles = 0, nwe = 0, hi, per;
   // Foreign registers answer with their own address and the top bit set
   wire [7:0] erd = {1'b1, ea};
   initial begin
      forever #20 clock_i = ~clock_i;
   end
   rcg_receiver_control_gpio_pwm DUT (.clock_i(clock_i), .rstn_i(rstn_i),
      .p1_sel_out2_i(p1oe ? p1o : sel), .p1_sel_out2_o(p1o), .p1_sel_out2_oe_o(p1oe),
      .p2_data_out1_i(p2oe ? p2o : 1'b1), .p2_data_out1_o(p2o), .p2_data_out1_oe_o(p2oe),
      .p3_clock_out0_i(p3oe ? p3o : sck), .p3_clock_out0_o(p3o), .p3_clock_out0_oe_o(p3oe),
      .p4_csn_in3_i(csn_n), .p6_din_in2_i(mosi), .p36_irq_out3_o(pwm),
      .general_inputs_lo_i(gin), .drive_boost_o(boost), .config_load_done_i(load),
      .config_exec_ok_i(ok), .config_gpio_sel_i(gsel), .mirror_enable_i(mir),
      .transmitter_digital_inputs_i(tdi), .wake_flag_i(wake), .ext_addr_o(ea),
      .ext_rdata_i(erd), .ext_we_o(we), .ext_waddr_o(wa), .ext_wdata_o(wd));
   rcg_spi_master mdl (.clock_i(clock_i), .miso_i(p2oe ? p2o : 1'b1), .sck_o(sck), .csn_n_o(csn_n),
      .mosi_o(mosi));
   ////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      mdl.frame(1'b1);
      mdl.xfer({1'b0, a}, x);
      mdl.xfer(d, x);
      mdl.frame(1'b0);
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
      mdl.frame(1'b1);
      mdl.xfer({1'b1, a}, x);
      mdl.xfer(8'h00, x);
      mdl.frame(1'b0);
      check(x, exp);
   endtask
   task automatic cfg_load(input logic e, input logic g);
      ok = e;
      gsel = g;
      load = 1'b1;
      @(negedge clock_i);
      load = 1'b0;
      repeat (3) @(negedge clock_i);
   endtask
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      nwe <= nwe + int'(we === 1'b1);
      if (cycles == 30000) begin
         miscompares++;
         end_of_test();
      end
   end
   ////////////////////////////////////////
   initial begin
      {sel, load, ok, gsel, mir, wake, gin, tdi} = '0;
      repeat (6) @(negedge clock_i);
      rstn_i = 1'b1;
      repeat (5) @(negedge clock_i);
      rdc(7'h06, 8'h00);
      for (int a = 'h41; a <= 'h43; a++) begin
         rdc(7'(a), 8'h00);
      end
      cfg_load(1'b1, 1'b0);
      rdc(7'h06, 8'h80);
      cfg_load(1'b0, 1'b0);
      wr(7'h06, 8'hff);
      rdc(7'h06, 8'h00);
      wr(7'h41, 8'ha5);
      check({p1oe, p3oe, 2'h0, boost}, 8'h00);
      mdl.frame(1'b1);
      mdl.xfer(8'h42, x);
      mdl.xfer(8'hc1, x);
      mdl.xfer(8'h40, x);
      mdl.frame(1'b0);
      mdl.frame(1'b1);
      mdl.xfer(8'hc1, x);
      mdl.xfer(8'h00, x);
      check(x, 8'ha5);
      mdl.xfer(8'h00, x);
      check(x, 8'hc1);
      mdl.xfer(8'h00, x);
      check(x, 8'h40);
      mdl.frame(1'b0);
      gin = 2'b10;
      rdc(7'h07, 8'h02);
      wr(7'h10, 8'h3c);
      check({1'b0, wa}, 8'h10);
      check(wd, 8'h3c);
      check(8'(nwe), 8'h01);
      rdc(7'h10, 8'h90);
      wake = 1'b1;
      repeat (2) @(negedge clock_i);
      check({7'h0, pwm}, 8'h01);
      wake = 1'b0;
      cfg_load(1'b1, 1'b1);
      check({boost, 1'b0, p1o, p2o, p3o}, 8'ha5);
      // Align to a rising edge of the PWM output, then time one high phase and one period
      while (pwm !== 1'b0) @(negedge clock_i);
      while (pwm !== 1'b1) @(negedge clock_i);
      hi = 0;
      while (pwm === 1'b1) begin
         hi++;
         @(negedge clock_i);
      end
      per = hi;
      while (pwm !== 1'b1) begin
         per++;
         @(negedge clock_i);
      end
      // Rate 1 gives 2 reference ticks per step; allow two cycles of accumulator jitter
      check({7'h0, (per * 40 - `RCG_PWM_PERIOD_TICKS * 2000000 / `RCG_REF_KHZ)
         inside {[-80:80]}}, 8'h01);
      check({7'h0, (hi * 40 - 64 * 2000000 / `RCG_REF_KHZ) inside {[-80:80]}}, 8'h01);
      mir = 1'b1;
      tdi = 3'b010;
      repeat (3) @(negedge clock_i);
      check({5'h0, p1o, p2o, p3o}, 8'h02);
      end_of_test();
   end
endmodule
